/* hw/amp_pkg.sv */
`default_nettype none
package amp_pkg;
    localparam int AMP_ADDR_W = 6;
    localparam int AMP_DATA_W = 8;
    localparam int AMP_NUM_REGS = 64;
    localparam logic AMP_DIR_READ = 1'h1;
    localparam logic AMP_DIR_WRITE = 1'h0;
    // interrupt condition and mask registers sit at these addresses
    localparam logic [AMP_ADDR_W-1:0] AMP_ADDR_INT_COND = 6'h02;
    localparam logic [AMP_ADDR_W-1:0] AMP_ADDR_INT_MASK = 6'h03;
    localparam int AMP_PERR_BIT = 0;
    localparam logic [AMP_DATA_W-1:0] AMP_REG_RESET = 8'h00;
    // host waits one cycle more than this count after driving pins before dropping enable
    localparam logic [3:0] AMP_SETUP_CYCLES = 4'h2;
    typedef logic [AMP_ADDR_W-1:0] amp_addr_t;
    typedef logic [AMP_DATA_W-1:0] amp_data_t;
endpackage
`default_nettype wire

/* hw/amp_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface amp_if;
    logic port_en_n;
    logic dir_read;
    logic [5:0] reg_addr;
    logic [7:0] host_data;
    logic host_data_oe;
    logic host_parity;
    logic [7:0] dev_data;
    logic dev_data_oe;
    logic dev_parity;
    logic ack_n_oe;
    logic int_n_oe;
    // resolved wire levels: open-drain lines pulled up when nobody sinks them
    logic ack_n;
    logic int_n;
    logic [7:0] bus_data;
    logic bus_parity;
    assign ack_n = ~ack_n_oe;
    assign int_n = ~int_n_oe;
    assign bus_data = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hFF);
    assign bus_parity = dev_data_oe ? dev_parity : (host_data_oe ? host_parity : 1'h1);
    modport device (input port_en_n, input dir_read, input reg_addr, input bus_data,
        input bus_parity, output dev_data, output dev_data_oe, output dev_parity,
        output ack_n_oe, output int_n_oe);
    modport host (output port_en_n, output dir_read, output reg_addr, output host_data,
        output host_data_oe, output host_parity, input bus_data, input bus_parity,
        input ack_n, input int_n);
endinterface
`default_nettype wire

/* hw/amp_device.sv */
`timescale 1ns/10ps
`default_nettype none
module amp_device
    import amp_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    amp_if.device bus,
    input wire logic [amp_pkg::AMP_DATA_W-1:0] event_set,
    output logic [amp_pkg::AMP_DATA_W-1:0] int_cond,
    output logic write_pulse,
    output logic [amp_pkg::AMP_ADDR_W-1:0] write_addr
);
    import amp_pkg::*;

    typedef enum logic [1:0] {
        AMP_IDLE = 2'b00,
        AMP_ACT = 2'b01,
        AMP_HOLD = 2'b10
    } amp_state_t;

    // ----------------------------------------
    // enable synchroniser
    // ----------------------------------------
    logic en_meta_reg, en_meta_next;
    logic en_sync_reg, en_sync_next;

    // only the second flop is read; the first may settle late
    always_comb begin
        en_meta_next = ~bus.port_en_n;
        en_sync_next = en_meta_reg;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            en_meta_reg <= 1'h0;
            en_sync_reg <= 1'h0;
        end else begin
            en_meta_reg <= en_meta_next;
            en_sync_reg <= en_sync_next;
        end
    end

    // ----------------------------------------
    // register space and access sequencer
    // ----------------------------------------
    amp_data_t regs_reg [AMP_NUM_REGS];
    amp_state_t state_reg, state_next;
    amp_data_t rdata_reg, rdata_next;
    logic rpar_reg, rpar_next;
    logic drive_reg, drive_next;
    logic ack_reg, ack_next;
    amp_data_t cond_reg, cond_next;
    amp_data_t regs_next [AMP_NUM_REGS];
    logic wr_en;
    logic perr_set;
    logic cond_rd;
    logic par_ok;
    amp_data_t reg_word;
    logic [AMP_ADDR_W-1:0] wa_reg, wa_next;
    logic wp_reg, wp_next;

    assign reg_word = regs_reg[bus.reg_addr];
    // odd parity: data plus parity bit has an odd count of ones
    assign par_ok = ^{bus.bus_data, bus.bus_parity};

    always_comb begin
        state_next = state_reg;
        rdata_next = rdata_reg;
        rpar_next = rpar_reg;
        drive_next = drive_reg;
        ack_next = ack_reg;
        wr_en = 1'h0;
        perr_set = 1'h0;
        cond_rd = 1'h0;
        wa_next = wa_reg;
        wp_next = 1'h0;
        unique case (state_reg)
            AMP_IDLE: begin
                if (en_sync_reg) begin
                    state_next = AMP_ACT;
                end
            end
            AMP_ACT: begin
                if (bus.dir_read == AMP_DIR_READ) begin
                    cond_rd = (bus.reg_addr == AMP_ADDR_INT_COND);
                    rdata_next = cond_rd ? cond_reg : reg_word;
                    rpar_next = ~^(cond_rd ? cond_reg : reg_word);
                    drive_next = 1'h1;
                end else if (par_ok) begin
                    // condition register is read-only, so its address takes no write
                    wr_en = (bus.reg_addr != AMP_ADDR_INT_COND);
                    wa_next = bus.reg_addr;
                    wp_next = 1'h1;
                end else begin
                    perr_set = 1'h1;
                end
                ack_next = 1'h1;
                state_next = AMP_HOLD;
            end
            AMP_HOLD: begin
                // access frozen here until the synchronised enable drops
                if (!en_sync_reg) begin
                    ack_next = 1'h0;
                    drive_next = 1'h0;
                    state_next = AMP_IDLE;
                end
            end
            default: state_next = AMP_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= AMP_IDLE;
            rdata_reg <= AMP_REG_RESET;
            rpar_reg <= 1'h0;
            drive_reg <= 1'h0;
            ack_reg <= 1'h0;
            wa_reg <= '0;
            wp_reg <= 1'h0;
        end else begin
            state_reg <= state_next;
            rdata_reg <= rdata_next;
            rpar_reg <= rpar_next;
            drive_reg <= drive_next;
            ack_reg <= ack_next;
            wa_reg <= wa_next;
            wp_reg <= wp_next;
        end
    end

    // ----------------------------------------
    // interrupt condition register
    // ----------------------------------------
    always_comb begin
        cond_next = cond_reg;
        // read clears it; an error or event in the same cycle still wins
        if (cond_rd) begin
            cond_next = AMP_REG_RESET;
        end
        if (perr_set) begin
            cond_next[AMP_PERR_BIT] = 1'h1;
        end
        cond_next = cond_next | event_set;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cond_reg <= AMP_REG_RESET;
        end else begin
            cond_reg <= cond_next;
        end
    end

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    generate
        for (genvar i = 0; i < AMP_NUM_REGS; i++) begin : g_reg
            // only the addressed entry takes a good-parity write
            always_comb begin
                regs_next[i] = regs_reg[i];
                if (wr_en && bus.reg_addr == AMP_ADDR_W'(i)) begin
                    regs_next[i] = bus.bus_data;
                end
            end

            always_ff @(posedge clk) begin
                if (reset) begin
                    regs_reg[i] <= AMP_REG_RESET;
                end else begin
                    regs_reg[i] <= regs_next[i];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    assign bus.dev_data = rdata_reg;
    assign bus.dev_parity = rpar_reg;
    assign bus.dev_data_oe = drive_reg;
    assign bus.ack_n_oe = ack_reg;
    // unmasked pending condition sinks the interrupt line
    assign bus.int_n_oe = |(cond_reg & ~regs_reg[AMP_ADDR_INT_MASK]);
    assign int_cond = cond_reg;
    assign write_pulse = wp_reg;
    assign write_addr = wa_reg;
endmodule // amp_device
`default_nettype wire

/* hw/amp_host.sv */
`timescale 1ns/10ps
`default_nettype none
module amp_host
    import amp_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    amp_if.host bus,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_read,
    input wire logic [amp_pkg::AMP_ADDR_W-1:0] req_addr,
    input wire logic [amp_pkg::AMP_DATA_W-1:0] req_wdata,
    input wire logic req_bad_parity,
    output logic rsp_valid,
    output logic [amp_pkg::AMP_DATA_W-1:0] rsp_rdata,
    output logic rsp_parity_ok,
    output logic irq
);
    import amp_pkg::*;

    typedef enum logic [1:0] {
        AMP_H_IDLE = 2'b00,
        AMP_H_SETUP = 2'b01,
        AMP_H_WAIT = 2'b10,
        AMP_H_END = 2'b11
    } amp_hstate_t;

    amp_hstate_t state_reg, state_next;
    logic en_reg, en_next;
    logic rd_reg, rd_next;
    logic oe_reg, oe_next;
    logic par_reg, par_next;
    logic [AMP_ADDR_W-1:0] addr_reg, addr_next;
    logic [AMP_DATA_W-1:0] wd_reg, wd_next;
    logic [AMP_DATA_W-1:0] rd_data_reg, rd_data_next;
    logic pok_reg, pok_next;
    logic rv_reg, rv_next;
    logic [3:0] cnt_reg, cnt_next;

    always_comb begin
        state_next = state_reg;
        en_next = en_reg;
        rd_next = rd_reg;
        oe_next = oe_reg;
        par_next = par_reg;
        addr_next = addr_reg;
        wd_next = wd_reg;
        rd_data_next = rd_data_reg;
        pok_next = pok_reg;
        rv_next = 1'h0;
        cnt_next = cnt_reg;
        unique case (state_reg)
            AMP_H_IDLE: begin
                if (req_valid) begin
                    rd_next = req_read ? AMP_DIR_READ : AMP_DIR_WRITE;
                    addr_next = req_addr;
                    wd_next = req_wdata;
                    par_next = (~^req_wdata) ^ req_bad_parity;
                    oe_next = ~req_read;
                    cnt_next = 4'h0;
                    state_next = AMP_H_SETUP;
                end
            end
            AMP_H_SETUP: begin
                cnt_next = cnt_reg + 4'h1;
                if (cnt_reg == AMP_SETUP_CYCLES) begin
                    en_next = 1'h1;
                    state_next = AMP_H_WAIT;
                end
            end
            AMP_H_WAIT: begin
                // data, parity and address held until acknowledge
                if (!bus.ack_n) begin
                    rd_data_next = bus.bus_data;
                    pok_next = ^{bus.bus_data, bus.bus_parity};
                    en_next = 1'h0;
                    state_next = AMP_H_END;
                end
            end
            AMP_H_END: begin
                if (bus.ack_n) begin
                    oe_next = 1'h0;
                    rv_next = 1'h1;
                    state_next = AMP_H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= AMP_H_IDLE;
            en_reg <= 1'h0;
            rd_reg <= 1'h1;
            oe_reg <= 1'h0;
            par_reg <= 1'h0;
            addr_reg <= '0;
            wd_reg <= '0;
            rd_data_reg <= '0;
            pok_reg <= 1'h0;
            rv_reg <= 1'h0;
            cnt_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            en_reg <= en_next;
            rd_reg <= rd_next;
            oe_reg <= oe_next;
            par_reg <= par_next;
            addr_reg <= addr_next;
            wd_reg <= wd_next;
            rd_data_reg <= rd_data_next;
            pok_reg <= pok_next;
            rv_reg <= rv_next;
            cnt_reg <= cnt_next;
        end
    end

    assign bus.port_en_n = ~en_reg;
    assign bus.dir_read = rd_reg;
    assign bus.reg_addr = addr_reg;
    assign bus.host_data = wd_reg;
    assign bus.host_parity = par_reg;
    assign bus.host_data_oe = oe_reg;
    assign req_ready = (state_reg == AMP_H_IDLE);
    assign rsp_valid = rv_reg;
    assign rsp_rdata = rd_data_reg;
    assign rsp_parity_ok = pok_reg;
    assign irq = ~bus.int_n;
endmodule // amp_host
`default_nettype wire

/* tb/amp_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module amp_asserts (
    input wire logic clk,
    input wire logic reset,
    input wire logic port_en_n,
    input wire logic dir_read,
    input wire logic [7:0] bus_data,
    input wire logic bus_parity,
    input wire logic dev_data_oe,
    input wire logic ack_n_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ----------------------------------------
    // access steps
    // ----------------------------------------
    sequence s_enable_fall;
        $fell(port_en_n) ##0 !ack_n_oe;
    endsequence
    sequence s_ack_arrives;
        ##[2:6] ack_n_oe;
    endsequence
    a_ack_after_enable: assert property (s_enable_fall |-> s_ack_arrives)
        else $error("acknowledge missing after enable fell");
    a_ack_holds: assert property (ack_n_oe && !port_en_n |=> ack_n_oe)
        else $error("acknowledge dropped while enable low");
    a_ack_released: assert property ($rose(port_en_n) |-> ##[1:5] !ack_n_oe)
        else $error("acknowledge not released");
    a_lines_released: assert property ($rose(port_en_n) |-> ##[1:5] !dev_data_oe)
        else $error("data lines still driven");
    a_ack_needs_en: assert property ($rose(ack_n_oe) |-> !port_en_n && !$past(port_en_n, 2))
        else $error("acknowledge without enable");
    a_one_access: assert property (!ack_n_oe && port_en_n |=> !ack_n_oe)
        else $error("second acknowledge in one enable period");
    a_read_drive: assert property (ack_n_oe && !port_en_n && dir_read |->
        dev_data_oe && ^{bus_data, bus_parity})
        else $error("read data or parity wrong");
    a_write_quiet: assert property (ack_n_oe && !port_en_n && !dir_read |-> !dev_data_oe)
        else $error("device drove lines on write");
    a_read_stable: assert property (dev_data_oe && $past(dev_data_oe) |-> $stable(bus_data))
        else $error("read data changed");
endmodule // amp_asserts
`default_nettype wire

/* tb/async_mgmt_register_port_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module async_mgmt_register_port_tb;
    import amp_pkg::*;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic [7:0] event_set = 8'h00;
    logic req_valid = 1'h0;
    logic req_read = 1'h0;
    logic req_bad_parity = 1'h0;
    amp_addr_t req_addr = 6'h00;
    amp_data_t req_wdata = 8'h00;
    logic req_ready, rsp_valid, rsp_parity_ok, irq, write_pulse;
    amp_data_t rsp_rdata, int_cond;
    amp_addr_t write_addr;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    int pulses = 0;
    amp_addr_t addrs [5] = '{6'h00, 6'h01, 6'h15, 6'h2A, 6'h3F};
    amp_if bus_if ();
    amp_device amp_device_i (.clk(clk), .reset(reset), .bus(bus_if.device),
        .event_set(event_set), .int_cond(int_cond), .write_pulse(write_pulse),
        .write_addr(write_addr));
    amp_host amp_host_i (.clk(clk), .reset(reset), .bus(bus_if.host), .req_valid(req_valid),
        .req_ready(req_ready), .req_read(req_read), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_bad_parity(req_bad_parity), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_parity_ok(rsp_parity_ok), .irq(irq));
    amp_asserts amp_asserts_i (.clk(clk), .reset(reset), .port_en_n(bus_if.port_en_n),
        .dir_read(bus_if.dir_read), .bus_data(bus_if.bus_data),
        .bus_parity(bus_if.bus_parity), .dev_data_oe(bus_if.dev_data_oe),
        .ack_n_oe(bus_if.ack_n_oe));
    always #2 clk = ~clk;
    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (miscompares == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // whole run is some 21 accesses of about 14 cycles; the ceiling leaves wide margin
    always @(posedge clk) begin
        cycles++;
        if (!reset && write_pulse === 1'h1) pulses++;
        if (cycles == 3000) begin
            miscompares++;
            final_report();
        end
    end
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic xfer(input logic rd, input amp_addr_t a, input amp_data_t d,
        input logic bad);
        int n;
        n = 0;
        @(posedge clk);
        while (req_ready !== 1'h1) @(posedge clk);
        req_valid <= 1'h1;
        req_read <= rd;
        req_addr <= a;
        req_wdata <= d;
        req_bad_parity <= bad;
        @(posedge clk);
        req_valid <= 1'h0;
        // response is a single-cycle pulse, so look at every falling edge
        @(negedge clk);
        while (rsp_valid !== 1'h1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (n == 40) check(8'h00, 8'hFF);
    endtask
    task automatic rd_check(input amp_addr_t a, input amp_data_t exp);
        xfer(1'h1, a, 8'h00, 1'h0);
        check(rsp_rdata, exp);
        check({7'h00, rsp_parity_ok}, 8'h01);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'h0;
        @(negedge clk);
        check({6'h00, bus_if.ack_n, irq}, 8'h02);
        check(int_cond, 8'h00);
        // back-to-back writes across the full address range, then read back
        foreach (addrs[i]) begin
            xfer(1'h0, addrs[i], 8'hA5 ^ {2'h0, addrs[i]}, 1'h0);
            check({2'h0, write_addr}, {2'h0, addrs[i]});
        end
        check(pulses[7:0], 8'h05);
        // a write to the read-only condition register must not set any condition
        xfer(1'h0, AMP_ADDR_INT_COND, 8'h5A, 1'h0);
        check(int_cond, 8'h00);
        check({7'h00, irq}, 8'h00);
        check({2'h0, write_addr}, {2'h0, AMP_ADDR_INT_COND});
        check(pulses[7:0], 8'h06);
        foreach (addrs[i]) rd_check(addrs[i], 8'hA5 ^ {2'h0, addrs[i]});
        // bad parity: write blocked, error flagged, interrupt raised
        xfer(1'h0, 6'h15, 8'h3C, 1'h1);
        rd_check(6'h15, 8'hA5 ^ 8'h15);
        check({7'h00, irq}, 8'h01);
        rd_check(AMP_ADDR_INT_COND, 8'h01 << AMP_PERR_BIT);
        check({7'h00, irq}, 8'h00);
        // masked condition stays off the pin until unmasked
        xfer(1'h0, AMP_ADDR_INT_MASK, 8'h01 << AMP_PERR_BIT, 1'h0);
        xfer(1'h0, 6'h00, 8'h77, 1'h1);
        check(int_cond, 8'h01 << AMP_PERR_BIT);
        check({7'h00, irq}, 8'h00);
        xfer(1'h0, AMP_ADDR_INT_MASK, 8'h00, 1'h0);
        check({7'h00, irq}, 8'h01);
        rd_check(6'h00, 8'hA5);
        rd_check(AMP_ADDR_INT_COND, 8'h01 << AMP_PERR_BIT);
        // an outside event sets its own condition bit
        @(posedge clk);
        event_set <= 8'h08;
        @(posedge clk);
        event_set <= 8'h00;
        @(negedge clk);
        check({7'h00, irq}, 8'h01);
        rd_check(AMP_ADDR_INT_COND, 8'h08);
        rd_check(AMP_ADDR_INT_COND, 8'h00);
        check({7'h00, bus_if.ack_n}, 8'h01);
        check(pulses[7:0], 8'h08);
        final_report();
    end
endmodule // async_mgmt_register_port_tb
`default_nettype wire
